// file: hdl/rci_consts.svh
// offsets, field positions, reset values and counts for the reset and cycle clock block
`ifndef RCI_CONSTS_SVH
`define RCI_CONSTS_SVH

`define RCI_OFF_CTRL    12'h000
`define RCI_OFF_STATUS  12'h004
`define RCI_OFF_ACC     12'h008
`define RCI_OFF_RAMADDR 12'h00c
`define RCI_OFF_PC      12'h010
`define RCI_OFF_EN      12'h014
`define RCI_OFF_QLATCH  12'h018
`define RCI_OFF_GLATCH  12'h01c
`define RCI_OFF_DPORT   12'h020
`define RCI_OFF_SHIFTER 12'h024
`define RCI_OFF_CARRY   12'h028
`define RCI_OFF_CMD     12'h02c
`define RCI_OFF_SAVE0   12'h030
`define RCI_OFF_SAVE1   12'h034
`define RCI_OFF_SAVE2   12'h038
`define RCI_RAM_PAGE    4'h1

`define RCI_CTRL_SRC_LO 0
`define RCI_CTRL_DIV8   2
`define RCI_CTRL_AUXIN  3
`define RCI_CTRL_REDPIN 4
`define RCI_CTRL_RESET  5'h00

`define RCI_CMD_READ_INPUT_LATCHES_INSTR    0
`define RCI_CMD_PUSH    1
`define RCI_CMD_POP     2

`define RCI_EN_LDRV     2

`define RCI_DIV_XTAL    5'd16
`define RCI_DIV_OPT     5'd8
`define RCI_DIV_RC      5'd4
`define RCI_RESET_CYCLES 2'd3

`endif

// file: hdl/rci_pkg.sv
// types shared by the reset and cycle clock block
package rci_pkg;
    typedef enum logic [1:0] {
        RCI_SRC_XTAL = 2'b00,
        RCI_SRC_EXT  = 2'b01,
        RCI_SRC_RC   = 2'b10,
        RCI_SRC_SYNC = 2'b11
    } rci_src_e;

    // gray along run -> low1 -> low2 -> init
    typedef enum logic [1:0] {
        RCI_RQ_RUN  = 2'b00,
        RCI_RQ_LOW1 = 2'b01,
        RCI_RQ_LOW2 = 2'b11,
        RCI_RQ_INIT = 2'b10
    } rci_rq_e;

    typedef struct packed {
        logic     reduced_pin;
        logic     aux_gen_input;
        logic     div8;
        rci_src_e src;
    } rci_ctrl_s;
endpackage

// file: hdl/rci_cycle_div.sv
// instruction cycle pulse generator for crystal, external, rc and sync sources
`timescale 1ns/100ps
`include "rci_consts.svh"
module rci_cycle_div
    import rci_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire logic      ce,
    input  wire rci_ctrl_s ctrl,
    input  wire logic      osc_in,
    input  wire logic      aux_in,
    output logic           cycle_pulse
);
    logic       osc_prev_q;
    logic       aux_prev_q;
    logic [4:0] cnt_q;
    logic [4:0] period;
    logic       osc_rise;
    logic       aux_rise;

    // rc divides by four; crystal and external clock by sixteen or the eight option
    always_comb
    begin
        if (ctrl.src == RCI_SRC_RC)
            period = `RCI_DIV_RC;
        else if (ctrl.div8)
            period = `RCI_DIV_OPT;
        else
            period = `RCI_DIV_XTAL;
    end

    assign osc_rise = osc_in & ~osc_prev_q;
    assign aux_rise = aux_in & ~aux_prev_q;

    // edge history of both clock pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_prev_q <= 1'b0;
            aux_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            osc_prev_q <= osc_in;
            aux_prev_q <= aux_in;
        end
    end

    // period counter; in sync mode the peer's pulse on the aux pin sets the cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q       <= 5'h00;
            cycle_pulse <= 1'b0;
        end
        else if (ce)
        begin
            if (ctrl.src == RCI_SRC_SYNC)
            begin
                cnt_q       <= 5'h00;
                cycle_pulse <= aux_rise;
            end
            else if (osc_rise && (cnt_q >= period - 5'h01))
            begin
                cnt_q       <= 5'h00;
                cycle_pulse <= 1'b1;
            end
            else
            begin
                cnt_q       <= osc_rise ? cnt_q + 5'h01 : cnt_q;
                cycle_pulse <= 1'b0;
            end
        end
    end

    // a cycle pulse always follows an edge of the selected source
    pulse_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && $past(ce) && $rose(cycle_pulse)) |->
            $past(ctrl.src == RCI_SRC_SYNC ? aux_rise : osc_rise))
        else $error("cycle pulse without a source edge");
endmodule // rci_cycle_div

// file: hdl/rci_reset_qual.sv
// reset pin qualifier: three low samples, one per instruction cycle
`timescale 1ns/100ps
`include "rci_consts.svh"
module rci_reset_qual
    import rci_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic cycle_pulse,
    input  wire logic reset_pin_n,
    output logic      init_q
);
    rci_rq_e state_q;

    // power-up clear starts in init, same effect as a qualified pin reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= RCI_RQ_INIT;
        else if (ce && cycle_pulse)
        begin
            case (state_q)
                RCI_RQ_RUN:  state_q <= reset_pin_n ? RCI_RQ_RUN : RCI_RQ_LOW1;
                RCI_RQ_LOW1: state_q <= reset_pin_n ? RCI_RQ_RUN : RCI_RQ_LOW2;
                RCI_RQ_LOW2: state_q <= reset_pin_n ? RCI_RQ_RUN : RCI_RQ_INIT;
                default:     state_q <= reset_pin_n ? RCI_RQ_RUN : RCI_RQ_INIT;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            init_q <= 1'b1;
        else if (ce && cycle_pulse)
            init_q <= !reset_pin_n && (state_q == RCI_RQ_LOW2 || state_q == RCI_RQ_INIT);
    end

    // init may only begin from low2, on the third low sample
    init_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(init_q) |-> $past(state_q == RCI_RQ_LOW2 && cycle_pulse && ce))
        else $error("init entered without three low samples");
endmodule // rci_reset_qual

// file: hdl/rci_top.sv
// reset, cycle clock and architectural register core with apb access
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "rci_consts.svh"
module rci_top
    import rci_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        reset_pin_n,
    input  wire logic        oscillator_input_pin,
    input  wire logic        auxiliary_oscillator_pin,
    input  wire logic [3:0]  gen_in,
    output logic             shift_clock_output,
    output logic [7:0]       lport_out,
    output logic             lport_oe,
    output logic [3:0]       dport_out,
    output logic [3:0]       gport_out,
    output logic             init_active
);
    rci_ctrl_s  ctrl_q;
    logic       cycle_pulse;
    logic       init;
    logic [3:0] acc_q;
    logic [1:0] ram_row_field_q;
    logic [3:0] ram_digit_field_q;
    logic [9:0] pc_q;
    logic [9:0] return_save_first_q;
    logic [9:0] return_save_second_q;
    logic [9:0] return_save_third_q;
    logic [3:0] en_q;
    logic [7:0] q_latch_q;
    logic [3:0] g_latch_q;
    logic [3:0] d_q;
    logic [3:0] shifter_counter_q;
    logic       carry_q;
    logic [1:0] input_edge_latches_q;
    logic [3:0] gen_prev_q;
    logic [3:0] ram_mem [0:63];
    logic       acc_phase;
    logic       wr_fire;
    logic       is_ram;
    logic       mapped;
    logic [5:0] ram_idx;
    logic       read_input_latches_instr_cmd;
    logic       push_cmd;
    logic       pop_cmd;
    logic [1:0] il_set;
    logic [31:0] rd_d;

    rci_cycle_div u_div (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .ctrl        (ctrl_q),
        .osc_in      (oscillator_input_pin),
        .aux_in      (auxiliary_oscillator_pin),
        .cycle_pulse (cycle_pulse)
    );

    rci_reset_qual u_rq (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .cycle_pulse (cycle_pulse),
        .reset_pin_n (reset_pin_n),
        .init_q      (init)
    );

    // bus decode; one wait state so read data comes from a flop
    assign acc_phase = psel && penable && ce;
    assign wr_fire   = acc_phase && pready && pwrite && !pslverr;
    assign is_ram    = (paddr[11:8] == `RCI_RAM_PAGE);
    assign ram_idx   = paddr[7:2];
    assign read_input_latches_instr_cmd  = wr_fire && paddr == `RCI_OFF_CMD && pwdata[`RCI_CMD_READ_INPUT_LATCHES_INSTR];
    assign push_cmd  = wr_fire && paddr == `RCI_OFF_CMD && pwdata[`RCI_CMD_PUSH];
    assign pop_cmd   = wr_fire && paddr == `RCI_OFF_CMD && pwdata[`RCI_CMD_POP];

    // falling edges on the top and bottom general inputs; none on the reduced part
    assign il_set = ctrl_q.reduced_pin ? 2'b00 :
                    {gen_prev_q[3] & ~gen_in[3], gen_prev_q[0] & ~gen_in[0]};

    // read mux and address check
    always_comb
    begin
        rd_d   = 32'h0000_0000;
        mapped = 1'b1;
        if (is_ram)
            rd_d = {28'h000_0000, ram_mem[ram_idx]};
        else if (paddr == `RCI_OFF_CTRL)
            rd_d = {27'h000_0000, ctrl_q};
        else if (paddr == `RCI_OFF_STATUS)
            rd_d = {28'h000_0000, input_edge_latches_q, cycle_pulse, init};
        else if (paddr == `RCI_OFF_ACC)
            rd_d = {28'h000_0000, acc_q};
        else if (paddr == `RCI_OFF_RAMADDR)
            rd_d = {26'h000_0000, ram_row_field_q, ram_digit_field_q};
        else if (paddr == `RCI_OFF_PC)
            rd_d = {22'h00_0000, pc_q};
        else if (paddr == `RCI_OFF_EN)
            rd_d = {28'h000_0000, en_q};
        else if (paddr == `RCI_OFF_QLATCH)
            rd_d = {24'h00_0000, q_latch_q};
        else if (paddr == `RCI_OFF_GLATCH)
            rd_d = {28'h000_0000, g_latch_q};
        else if (paddr == `RCI_OFF_DPORT)
            rd_d = {28'h000_0000, d_q};
        else if (paddr == `RCI_OFF_SHIFTER)
            rd_d = {28'h000_0000, shifter_counter_q};
        else if (paddr == `RCI_OFF_CARRY)
            rd_d = {31'h0000_0000, carry_q};
        else if (paddr == `RCI_OFF_CMD)
            rd_d = 32'h0000_0000;
        else if (paddr == `RCI_OFF_SAVE0)
            rd_d = {22'h00_0000, return_save_first_q};
        else if (paddr == `RCI_OFF_SAVE1)
            rd_d = {22'h00_0000, return_save_second_q};
        else if (paddr == `RCI_OFF_SAVE2)
            rd_d = {22'h00_0000, return_save_third_q};
        else
            mapped = 1'b0;
    end

    // apb handshake: ready one cycle into the access phase, then dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready  <= acc_phase && !pready;
            pslverr <= acc_phase && !pready && !mapped;
            prdata  <= (acc_phase && !pready && !pwrite) ? rd_d : 32'h0000_0000;
        end
    end

    // data memory has no reset and init never touches it
    always_ff @(posedge pclk)
    begin
        if (wr_fire && is_ram)
            ram_mem[ram_idx] <= pwdata[3:0];
    end

    // configuration; not part of the init clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= `RCI_CTRL_RESET;
        else if (ce && wr_fire && paddr == `RCI_OFF_CTRL)
            ctrl_q <= pwdata[4:0];
    end

    // accumulator: init clear wins, then input-latch read, then bus write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_q <= 4'h0;
        else if (ce)
        begin
            if (init)
                acc_q <= 4'h0;
            else if (read_input_latches_instr_cmd)
                acc_q <= {input_edge_latches_q[1],
                          ctrl_q.aux_gen_input & auxiliary_oscillator_pin,
                          1'b0, input_edge_latches_q[0]};
            else if (wr_fire && paddr == `RCI_OFF_ACC)
                acc_q <= pwdata[3:0];
        end
    end

    // registers that init clears
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ram_row_field_q   <= 2'h0;
            ram_digit_field_q <= 4'h0;
            pc_q              <= 10'h000;
            en_q              <= 4'h0;
            g_latch_q         <= 4'h0;
            d_q               <= 4'h0;
            carry_q           <= 1'b0;
        end
        else if (ce)
        begin
            if (init)
            begin
                ram_row_field_q   <= 2'h0;
                ram_digit_field_q <= 4'h0;
                pc_q              <= 10'h000;
                en_q              <= 4'h0;
                g_latch_q         <= 4'h0;
                d_q               <= 4'h0;
                carry_q           <= 1'b0;
            end
            else if (wr_fire)
            begin
                if (paddr == `RCI_OFF_RAMADDR)
                    {ram_row_field_q, ram_digit_field_q} <= pwdata[5:0];
                if (paddr == `RCI_OFF_PC)
                    pc_q <= pwdata[9:0];
                else if (pop_cmd)
                    pc_q <= return_save_first_q;
                if (paddr == `RCI_OFF_EN)
                    en_q <= pwdata[3:0];
                if (paddr == `RCI_OFF_GLATCH)
                    g_latch_q <= pwdata[3:0];
                if (paddr == `RCI_OFF_DPORT)
                    d_q <= pwdata[3:0];
                if (paddr == `RCI_OFF_CARRY)
                    carry_q <= pwdata[0];
            end
        end
    end

    // parallel latch and shifter keep their contents over init
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_latch_q         <= 8'h00;
            shifter_counter_q <= 4'h0;
        end
        else if (ce && wr_fire)
        begin
            if (paddr == `RCI_OFF_QLATCH)
                q_latch_q <= pwdata[7:0];
            if (paddr == `RCI_OFF_SHIFTER)
                shifter_counter_q <= pwdata[3:0];
        end
    end

    // three-deep return stack; deepest entry is lost on push
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            return_save_first_q  <= 10'h000;
            return_save_second_q <= 10'h000;
            return_save_third_q  <= 10'h000;
        end
        else if (ce && !init)
        begin
            if (push_cmd)
            begin
                return_save_first_q  <= pc_q + 10'h001;
                return_save_second_q <= return_save_first_q;
                return_save_third_q  <= return_save_second_q;
            end
            else if (pop_cmd)
            begin
                return_save_first_q  <= return_save_second_q;
                return_save_second_q <= return_save_third_q;
            end
        end
    end

    // edge latches: a falling edge in the clearing cycle still sets
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gen_prev_q           <= 4'hf;
            input_edge_latches_q <= 2'b00;
        end
        else if (ce)
        begin
            gen_prev_q           <= gen_in;
            input_edge_latches_q <= il_set | (read_input_latches_instr_cmd ? 2'b00 : input_edge_latches_q);
        end
    end

    // pin outputs; the l drivers go high impedance when the enable bit is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_clock_output <= 1'b0;
            lport_out          <= 8'h00;
            lport_oe           <= 1'b0;
            dport_out          <= 4'h0;
            gport_out          <= 4'h0;
            init_active        <= 1'b1;
        end
        else if (ce)
        begin
            shift_clock_output <= cycle_pulse && !init;
            lport_out          <= q_latch_q;
            lport_oe           <= en_q[`RCI_EN_LDRV] && !init;
            dport_out          <= d_q;
            gport_out          <= g_latch_q;
            init_active        <= init;
        end
    end

    // init leaves the program counter and accumulator at zero one cycle later
    init_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (init && ce) |=> (pc_q == 10'h000 && acc_q == 4'h0 && en_q == 4'h0))
        else $error("init did not clear core registers");

    // blanked drivers stay off while enable bit is low
    lport_blank_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !en_q[`RCI_EN_LDRV]) |=> !lport_oe)
        else $error("parallel drivers on while disabled");

    // sync output follows each cycle pulse outside init
    sk_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && cycle_pulse && !init) |=> shift_clock_output)
        else $error("shift clock missed a cycle pulse");

    // input-latch read places both latches and a zero bit 1 in the documented bits
    read_input_latches_instr_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        (read_input_latches_instr_cmd && !init) |=> (acc_q[1] == 1'b0 &&
            acc_q[3] == $past(input_edge_latches_q[1]) &&
            acc_q[0] == $past(input_edge_latches_q[0])))
        else $error("input latch read loaded wrong bits");

    // ready comes exactly one cycle into an access and lasts one cycle
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && !pready) ##1 ce |-> pready ##1 (!ce || !pready))
        else $error("apb ready timing wrong");

    // reduced part never sets an edge latch
    reduced_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && ctrl_q.reduced_pin && input_edge_latches_q == 2'b00) |=>
            input_edge_latches_q == 2'b00)
        else $error("edge latch set on reduced part");
endmodule // rci_top

// file: tb/rci_peer_model.sv
// far side model: oscillator source, peer sync pulse and external reset driver
`timescale 1ns/100ps
module rci_peer_model
    import rci_pkg::*;
(
    input  wire logic pclk,
    input  wire logic sync_en,
    input  wire logic aux_lvl,
    input  wire logic rst_req,
    output logic      osc,
    output logic      aux,
    output logic      rst_n
);
    logic [4:0] cnt_q = 5'h00;

    // source clock of four pclk periods, kept well below pclk/2
    always @(posedge pclk)
    begin
        cnt_q <= (cnt_q == 5'h17) ? 5'h00 : cnt_q + 5'h01;
    end

    // the wrap at 24 is a multiple of four, so the source period never stretches
    assign osc = cnt_q[1];

    // peer sends one sync pulse per 24 pclk; otherwise a plain level
    assign aux   = sync_en ? (cnt_q < 5'h02) : aux_lvl;
    // reset driver holds the pin low for as long as it is asked to
    assign rst_n = ~rst_req;
endmodule // rci_peer_model

// file: tb/testbench.sv
// self-checking bench for the reset and cycle clock block over apb
`timescale 1ns/100ps
`include "rci_consts.svh"
module testbench
    import rci_pkg::*;
;
    localparam int OSC_P = 4;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        rerr, rst_n, osc, aux, sync_en, aux_lvl, rst_req, seen;
    logic [3:0]  gen_in, dport_out, gport_out;
    logic [7:0]  lport_out;
    logic        lport_oe, shift_clock_output, init_active;
    int          fails = 0;
    int          checks = 0;
    int          k, p;
    logic [11:0] clr [7] = '{`RCI_OFF_ACC, `RCI_OFF_RAMADDR, `RCI_OFF_PC, `RCI_OFF_EN,
                             `RCI_OFF_GLATCH, `RCI_OFF_DPORT, `RCI_OFF_CARRY};
    logic [31:0] ctl [6] = '{32'h0, 32'h4, 32'h1, 32'h5, 32'h2, 32'h3};
    int          exp_p [6] = '{16 * OSC_P, 8 * OSC_P, 16 * OSC_P, 8 * OSC_P, 4 * OSC_P, 24};

    rci_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_pin_n(rst_n), .oscillator_input_pin(osc),
        .auxiliary_oscillator_pin(aux), .gen_in(gen_in),
        .shift_clock_output(shift_clock_output), .lport_out(lport_out), .lport_oe(lport_oe),
        .dport_out(dport_out), .gport_out(gport_out), .init_active(init_active));
    rci_peer_model u_peer (.pclk(pclk), .sync_en(sync_en), .aux_lvl(aux_lvl),
        .rst_req(rst_req), .osc(osc), .aux(aux), .rst_n(rst_n));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    // a wait that used up its bound ends the run as a failure
    task bound(input int i, input int lim);
        if (i >= lim)
        begin
            fails++;
            summarize();
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        bound(i, 20);
        @(posedge pclk);
    endtask

    task chk(input logic [11:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        cmp(n, e, rdat);
    endtask

    task wait_init;
        int i;
        for (i = 0; i < 300 && init_active !== 1'b0; i++)
            @(posedge pclk);
        cmp("init_active", 32'h0, {31'h0, init_active});
        if (i >= 300)
            summarize();
    endtask

    // pclk cycles between two shift clock pulses
    task per(output int n);
        int i;
        for (i = 0; i < 400 && shift_clock_output !== 1'b1; i++)
            @(posedge pclk);
        bound(i, 400);
        @(posedge pclk);
        for (n = 1; n < 400 && shift_clock_output !== 1'b1; n++)
            @(posedge pclk);
        bound(n, 400);
    endtask

    // reset pin low across n cycle samples in rc mode, noting any init
    task hold(input int n, output logic s);
        int i;
        s = 1'b0;
        for (i = 0; i < 100 && shift_clock_output !== 1'b1; i++)
            @(posedge pclk);
        bound(i, 100);
        rst_req <= 1'b1;
        repeat (n * 4 * OSC_P + 8)
        begin
            @(posedge pclk);
            s = s | init_active;
        end
        rst_req <= 1'b0;
        @(posedge pclk);
    endtask

    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {sync_en, aux_lvl, rst_req} = 3'b000;
        gen_in = 4'hf;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wait_init();
        for (k = 0; k < 7; k++)
            chk(clr[k], 32'h0, "cleared reg");
        apb(1'b1, `RCI_OFF_RAMADDR, 32'hff);
        chk(`RCI_OFF_RAMADDR, 32'h3f, "ramaddr");
        apb(1'b1, `RCI_OFF_PC, 32'h3fe);
        apb(1'b1, `RCI_OFF_CMD, 32'h2);
        chk(`RCI_OFF_SAVE0, 32'h3ff, "save0");
        apb(1'b1, `RCI_OFF_QLATCH, 32'ha5);
        apb(1'b1, `RCI_OFF_EN, 32'h4);
        // pin outputs are one flop behind the register that a write lands in
        @(posedge pclk);
        cmp("lport", 32'h1a5, {23'h0, lport_oe, lport_out});
        apb(1'b1, `RCI_OFF_EN, 32'h0);
        @(posedge pclk);
        cmp("lport_oe", 32'h0, {31'h0, lport_oe});
        apb(1'b1, `RCI_OFF_ACC, 32'h9);
        apb(1'b1, `RCI_OFF_GLATCH, 32'hf);
        apb(1'b1, `RCI_OFF_DPORT, 32'h6);
        @(posedge pclk);
        cmp("dport_out", 32'h6, {28'h0, dport_out});
        cmp("gport_out", 32'hf, {28'h0, gport_out});
        apb(1'b1, 12'h100, 32'ha);
        // every source and divider option in turn
        for (k = 0; k < 6; k++)
        begin
            sync_en <= (k == 5);
            apb(1'b1, `RCI_OFF_CTRL, ctl[k]);
            per(p);
            per(p);
            cmp("cycle period", exp_p[k], p);
        end
        sync_en <= 1'b0;
        apb(1'b1, `RCI_OFF_CTRL, 32'h2);
        hold(2, seen);
        cmp("two low samples", 32'h0, {31'h0, seen});
        hold(3, seen);
        cmp("three low samples", 32'h1, {31'h0, seen});
        wait_init();
        for (k = 0; k < 7; k++)
            chk(clr[k], 32'h0, "cleared reg");
        chk(12'h100, 32'ha, "data memory");
        cmp("gport_out", 32'h0, {28'h0, gport_out});
        // input latch read with aux as general input
        apb(1'b1, `RCI_OFF_CTRL, 32'ha);
        aux_lvl <= 1'b1;
        gen_in <= 4'h6;
        apb(1'b0, `RCI_OFF_STATUS, 32'h0);
        cmp("status", 32'hc, rdat & 32'hd);
        cmp("edge latches", 32'hc, rdat & 32'hc);
        apb(1'b1, `RCI_OFF_CMD, 32'h1);
        chk(`RCI_OFF_ACC, 32'hd, "input read");
        gen_in <= 4'hf;
        aux_lvl <= 1'b0;
        apb(1'b1, `RCI_OFF_CMD, 32'h1);
        chk(`RCI_OFF_ACC, 32'h0, "latches cleared");
        apb(1'b1, `RCI_OFF_CTRL, 32'h1a);
        aux_lvl <= 1'b1;
        gen_in <= 4'h6;
        apb(1'b1, `RCI_OFF_CMD, 32'h1);
        chk(`RCI_OFF_ACC, 32'h4, "reduced pin read");
        apb(1'b0, 12'h0fc, 32'h0);
        cmp("unmapped", 32'h1, {rdat[30:0], rerr});
        summarize();
    end
endmodule // testbench
